// File: hdl/csl_cfg.svh
// offsets, field positions, reset values and timing constants for the current-sense limit block
`ifndef CSL_CFG_SVH
`define CSL_CFG_SVH

// ==========================================================
// register offsets
`define CSL_ADDR_SENSE1_TRIP_DELAY 8'h1a
`define CSL_ADDR_SENSE2_GAIN_THRESHOLD 8'h1b
`define CSL_ADDR_SENSE2_TRIP_DELAY 8'h1c
`define CSL_ADDR_SENSE3_CONTROL 8'h1d
`define CSL_ADDR_SENSE3_TRIP_DELAY 8'h1e
`define CSL_ADDR_UNUSED_SLOT 8'h1f

// ==========================================================
// reset values
`define CSL_RST_SENSE1_TRIP_DELAY 8'h04
`define CSL_RST_SENSE2_GAIN_THRESHOLD 8'h1d
`define CSL_RST_SENSE2_TRIP_DELAY 8'h05
`define CSL_RST_SENSE3_CONTROL 8'h00
`define CSL_RST_SENSE3_TRIP_DELAY 8'h05
`define CSL_RST_UNUSED_SLOT 8'h00

// ==========================================================
// field positions
`define CSL_DELAY_MSB 5
`define CSL_GAIN_SEL_BIT 6
`define CSL_THRESH_MSB 4
`define CSL_THRESH_FLOOR_CODE 5'h04
`define CSL_THRESH_FLOOR_DV 6'h05
`define CSL_GAIN_LOW 6'h14
`define CSL_GAIN_HIGH 6'h28

// ==========================================================
// timing: clock rate and delay steps in microseconds
`define CSL_CLK_MHZ 250
`define CSL_STEP_ONE_US 5250
`define CSL_STEP_TWO_US 1050
`define CSL_STEP_ONE_CYCLES (`CSL_STEP_ONE_US * `CSL_CLK_MHZ)
`define CSL_STEP_TWO_CYCLES (`CSL_STEP_TWO_US * `CSL_CLK_MHZ)

`endif

// File: hdl/csl_pkg.sv
// types shared by the current-sense limit block
package csl_pkg;

  // ==========================================================
  // register access request from the configuration interface
  typedef struct packed {
    logic [7:0] addr;
    logic wr;
    logic rd;
    logic [7:0] wdata;
  } csl_reg_req_type;

  // ==========================================================
  // decoded channel two analog settings
  typedef struct packed {
    logic [5:0] amp_gain;
    logic [4:0] limit_threshold_two;
    logic [5:0] threshold_dv;
  } csl_sense2_cfg_type;

endpackage

// File: hdl/csl_regs.sv
// current-sense limit configuration registers and channel trip timing
`timescale 1ns/1ps
`include "csl_cfg.svh"
module csl_regs
  import csl_pkg::*;
#(
  parameter int STEP_ONE_CYCLES = `CSL_STEP_ONE_CYCLES,
  parameter int STEP_TWO_CYCLES = `CSL_STEP_TWO_CYCLES
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire csl_reg_req_type reg_req,
  output logic [7:0] reg_rdata,
  output logic reg_rvalid,
  output logic reg_hit,
  input wire logic [2:0] over_limit_pin,
  output logic [2:0] channel_trip,
  output csl_sense2_cfg_type sense2_cfg,
  output logic [7:0] sense3_ctrl
);

  // ==========================================================
  // register storage
  logic [5:0] trip_delay_one;
  logic amp_gain_select_two;
  logic [4:0] limit_threshold_two;
  logic [5:0] trip_delay_two;
  logic [7:0] sense3_control;
  logic [5:0] trip_delay_three;
  logic [7:0] unused_slot;
  logic [2:0] over_meta;
  logic [2:0] over_sync;
  logic [7:0] next_rdata;
  logic next_hit;

  // reset words held as constants so their fields can be sliced on purpose
  localparam logic [7:0] RST_DELAY_ONE = `CSL_RST_SENSE1_TRIP_DELAY;
  localparam logic [7:0] RST_GAIN_THR = `CSL_RST_SENSE2_GAIN_THRESHOLD;
  localparam logic [7:0] RST_DELAY_TWO = `CSL_RST_SENSE2_TRIP_DELAY;
  localparam logic [7:0] RST_DELAY_THREE = `CSL_RST_SENSE3_TRIP_DELAY;

  // threshold in tenths of a volt: codes up to four share the floor
  function automatic logic [5:0] thresh_dv(input logic [4:0] code);
    if (code <= `CSL_THRESH_FLOOR_CODE) begin
      thresh_dv = `CSL_THRESH_FLOOR_DV;
    end else begin
      thresh_dv = 6'(code) + 6'h01;
    end
  endfunction

  function automatic logic addr_is(input logic [7:0] a, input logic [7:0] b);
    addr_is = (a == b);
  endfunction

  // ==========================================================
  // write path; reserved bits are not stored so they read back zero
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      trip_delay_one <= RST_DELAY_ONE[5:0];
      amp_gain_select_two <= RST_GAIN_THR[6];
      limit_threshold_two <= RST_GAIN_THR[4:0];
      trip_delay_two <= RST_DELAY_TWO[5:0];
      sense3_control <= `CSL_RST_SENSE3_CONTROL;
      trip_delay_three <= RST_DELAY_THREE[5:0];
      unused_slot <= `CSL_RST_UNUSED_SLOT;
    end else if (reg_req.wr) begin
      if (addr_is(reg_req.addr, `CSL_ADDR_SENSE1_TRIP_DELAY)) begin
        trip_delay_one <= reg_req.wdata[`CSL_DELAY_MSB:0];
      end
      if (addr_is(reg_req.addr, `CSL_ADDR_SENSE2_GAIN_THRESHOLD)) begin
        amp_gain_select_two <= reg_req.wdata[`CSL_GAIN_SEL_BIT];
        limit_threshold_two <= reg_req.wdata[`CSL_THRESH_MSB:0];
      end
      if (addr_is(reg_req.addr, `CSL_ADDR_SENSE2_TRIP_DELAY)) begin
        trip_delay_two <= reg_req.wdata[`CSL_DELAY_MSB:0];
      end
      if (addr_is(reg_req.addr, `CSL_ADDR_SENSE3_CONTROL)) begin
        sense3_control <= reg_req.wdata;
      end
      if (addr_is(reg_req.addr, `CSL_ADDR_SENSE3_TRIP_DELAY)) begin
        trip_delay_three <= reg_req.wdata[`CSL_DELAY_MSB:0];
      end
      if (addr_is(reg_req.addr, `CSL_ADDR_UNUSED_SLOT)) begin
        unused_slot <= reg_req.wdata;
      end
    end
  end

  // ==========================================================
  // read mux; unmapped addresses answer zero with the hit flag low
  always_comb begin
    next_rdata = 8'h00;
    next_hit = 1'b1;
    unique case (reg_req.addr)
      `CSL_ADDR_SENSE1_TRIP_DELAY: next_rdata = {2'h0, trip_delay_one};
      `CSL_ADDR_SENSE2_GAIN_THRESHOLD: begin
        next_rdata = {1'b0, amp_gain_select_two, 1'b0, limit_threshold_two};
      end
      `CSL_ADDR_SENSE2_TRIP_DELAY: next_rdata = {2'h0, trip_delay_two};
      `CSL_ADDR_SENSE3_CONTROL: next_rdata = sense3_control;
      `CSL_ADDR_SENSE3_TRIP_DELAY: next_rdata = {2'h0, trip_delay_three};
      `CSL_ADDR_UNUSED_SLOT: next_rdata = unused_slot;
      default: next_hit = 1'b0;
    endcase
  end

  // read answer is registered one cycle after the request
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      reg_rdata <= 8'h00;
      reg_rvalid <= 1'b0;
      reg_hit <= 1'b0;
    end else begin
      reg_rvalid <= reg_req.rd;
      if (reg_req.rd) begin
        reg_rdata <= next_rdata;
        reg_hit <= next_hit;
      end
    end
  end

  // ==========================================================
  // decoded analog settings, registered so the analog side sees clean levels
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      sense2_cfg <= '0;
      sense3_ctrl <= 8'h00;
    end else begin
      sense2_cfg.amp_gain <= amp_gain_select_two ? `CSL_GAIN_HIGH : `CSL_GAIN_LOW;
      sense2_cfg.limit_threshold_two <= limit_threshold_two;
      sense2_cfg.threshold_dv <= thresh_dv(limit_threshold_two);
      sense3_ctrl <= sense3_control;
    end
  end

  // ==========================================================
  // comparator outputs are asynchronous to ref_clk: two-flop synchroniser
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      over_meta <= 3'h0;
      over_sync <= 3'h0;
    end else begin
      over_meta <= over_limit_pin;
      over_sync <= over_meta;
    end
  end

  // ==========================================================
  // per-channel persistence timers; channel one uses the coarse step
  csl_trip_timer #(
    .STEP_CYCLES(STEP_ONE_CYCLES)
  ) u_timer_one (
    .ref_clk(ref_clk),
    .rst(rst),
    .over_limit(over_sync[0]),
    .delay_code(trip_delay_one),
    .trip(channel_trip[0]),
    .held_cycles()
  );

  csl_trip_timer #(
    .STEP_CYCLES(STEP_TWO_CYCLES)
  ) u_timer_two (
    .ref_clk(ref_clk),
    .rst(rst),
    .over_limit(over_sync[1]),
    .delay_code(trip_delay_two),
    .trip(channel_trip[1]),
    .held_cycles()
  );

  // same scale as channel two by sharing its step parameter
  csl_trip_timer #(
    .STEP_CYCLES(STEP_TWO_CYCLES)
  ) u_timer_three (
    .ref_clk(ref_clk),
    .rst(rst),
    .over_limit(over_sync[2]),
    .delay_code(trip_delay_three),
    .trip(channel_trip[2]),
    .held_cycles()
  );

  // ==========================================================
  // checks
  sequence s_wr_unused;
    reg_req.wr && addr_is(reg_req.addr, `CSL_ADDR_UNUSED_SLOT);
  endsequence

  a_zero_delay_trip: assert property (@(posedge ref_clk) disable iff (rst)
    (over_sync[0] && trip_delay_one == 6'h00) |=> channel_trip[0])
    else $error("zero delay did not trip at once");

  a_gain_map: assert property (@(posedge ref_clk) disable iff (rst)
    $stable(amp_gain_select_two) |=>
      sense2_cfg.amp_gain == ($past(amp_gain_select_two) ? 6'h28 : 6'h14))
    else $error("gain select decoded wrongly");

  a_thresh_map: assert property (@(posedge ref_clk) disable iff (rst)
    1'b1 |=> sense2_cfg.threshold_dv ==
      (($past(limit_threshold_two) <= 5'h04) ? 6'h05 : 6'($past(limit_threshold_two)) + 6'h01))
    else $error("threshold decoded wrongly");

  a_delay_two_hold: assert property (@(posedge ref_clk) disable iff (rst)
    (!over_sync[1] ##1 over_sync[1] && trip_delay_two != 6'h00) |=> !channel_trip[1])
    else $error("channel two tripped before its delay");

  a_delay_three_hold: assert property (@(posedge ref_clk) disable iff (rst)
    (!over_sync[2] ##1 over_sync[2] && trip_delay_three != 6'h00) |=> !channel_trip[2])
    else $error("channel three tripped before its delay");

  a_unused_inert: assert property (@(posedge ref_clk) disable iff (rst)
    s_wr_unused |=> $stable(trip_delay_one) && $stable(trip_delay_two)
      && $stable(trip_delay_three) && $stable(limit_threshold_two)
      && unused_slot == $past(reg_req.wdata))
    else $error("unused slot write disturbed other state");

  a_trip_drops: assert property (@(posedge ref_clk) disable iff (rst)
    !over_sync[1] |=> !channel_trip[1])
    else $error("trip held after condition cleared");

  a_trip_drops_all: assert property (@(posedge ref_clk) disable iff (rst)
    (over_sync == 3'h0) |=> (channel_trip == 3'h0))
    else $error("a trip stayed up with no channel over limit");

  // the spare slot answers like any mapped register, with its stored byte
  a_unused_readback: assert property (@(posedge ref_clk) disable iff (rst)
    (reg_req.rd && addr_is(reg_req.addr, `CSL_ADDR_UNUSED_SLOT)) |=>
      (reg_rvalid && reg_hit && reg_rdata == $past(unused_slot)))
    else $error("unused slot read back wrongly");

endmodule

// File: hdl/csl_trip_timer.sv
// persistence timer that qualifies one channel's over-limit condition
`timescale 1ns/1ps
module csl_trip_timer
  import csl_pkg::*;
#(
  parameter int STEP_CYCLES = 1
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic over_limit,
  input wire logic [5:0] delay_code,
  output logic trip,
  output logic [31:0] held_cycles
);

  logic [31:0] target;

  // ==========================================================
  // target length scales linearly with the code, zero means no wait
  assign target = 32'(delay_code) * 32'(STEP_CYCLES);

  // count how long the condition has been present; any gap restarts
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      held_cycles <= 32'h0;
    end else if (!over_limit) begin
      held_cycles <= 32'h0;
    end else if (held_cycles < target) begin
      held_cycles <= held_cycles + 32'h1;
    end
  end

  // trip once held long enough; saturating count keeps trip asserted
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      trip <= 1'b0;
    end else begin
      trip <= over_limit && (held_cycles >= target);
    end
  end

  // ==========================================================
  // checks
  a_trip_needs_hold: assert property (@(posedge ref_clk) disable iff (rst)
    trip |-> $past(over_limit) && ($past(held_cycles) >= $past(target)))
    else $error("trip raised before the delay expired");

  a_clear_restarts: assert property (@(posedge ref_clk) disable iff (rst)
    !over_limit |=> (held_cycles == 32'h0) && !trip)
    else $error("timer not restarted after condition cleared");

  a_step_growth: assert property (@(posedge ref_clk) disable iff (rst)
    (over_limit && $stable(delay_code) && held_cycles < target) |=>
      (!over_limit || held_cycles == $past(held_cycles) + 32'h1))
    else $error("timer did not advance while over limit");

endmodule

// File: sim/tb.sv
// self-checking bench for the current-sense limit registers and trip timing
`timescale 1ns/1ps
module tb
  import csl_pkg::*;
;

  // ==========================================================
  // clock, reset and design hookup
  localparam int S1 = 5; // shortened steps keep the 5:1 ratio of the real scales
  localparam int S2 = 1;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  csl_reg_req_type reg_req = '0;
  logic [2:0] over_limit_pin = 3'h0;
  logic [7:0] reg_rdata;
  logic reg_rvalid;
  logic reg_hit;
  logic [2:0] channel_trip;
  csl_sense2_cfg_type sense2_cfg;
  logic [7:0] sense3_ctrl;
  int miscompares = 0;
  int n_checks = 0;
  int seed = 49707;
  logic [8:0] exp_q[$]; // pending read answers: {hit, data}
  logic [7:0] shadow[6];
  logic [7:0] mask[6] = '{8'h3f, 8'h5f, 8'h3f, 8'hff, 8'h3f, 8'hff};

  always #2 ref_clk = ~ref_clk;

  csl_regs #(.STEP_ONE_CYCLES(S1), .STEP_TWO_CYCLES(S2)) i_csl_regs (
    .ref_clk(ref_clk),
    .rst(rst),
    .reg_req(reg_req),
    .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid),
    .reg_hit(reg_hit),
    .over_limit_pin(over_limit_pin),
    .channel_trip(channel_trip),
    .sense2_cfg(sense2_cfg),
    .sense3_ctrl(sense3_ctrl)
  );

  // ==========================================================
  // comparison, verdict and bus tasks
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic results();
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // strobes stay up between calls so back-to-back transfers need no re-raise
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_req.addr = a;
    reg_req.wdata = d;
    reg_req.rd = 1'b0;
    reg_req.wr = 1'b1;
    @(posedge ref_clk);
    #1;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] d, input logic h);
    exp_q.push_back({h, d});
    reg_req.addr = a;
    reg_req.wr = 1'b0;
    reg_req.rd = 1'b1;
    @(posedge ref_clk);
    #1;
  endtask

  task automatic idle();
    reg_req.wr = 1'b0;
    reg_req.rd = 1'b0;
    @(posedge ref_clk);
    #1;
  endtask

  // watcher: every read answer retires the oldest note; sampled mid-cycle,
  // where the registered answer has settled rather than at its launch edge
  always @(negedge ref_clk) begin
    if (reg_rvalid === 1'b1) begin
      if (exp_q.size() == 0) begin
        check("unexpected rvalid", 1, 0);
      end else begin
        check("read data", reg_rdata, exp_q[0][7:0]);
        check("read hit", reg_hit, exp_q[0][8]);
        void'(exp_q.pop_front());
      end
    end
  end

  // ==========================================================
  // trip timing: pin high until trip, then low until trip drops
  task automatic trip(input int ch, input logic [5:0] code, input int step);
    int n;
    wr(8'h1a + 8'(2 * ch), {2'b00, code});
    idle();
    over_limit_pin[ch] = 1'b1;
    n = 0;
    while (channel_trip[ch] !== 1'b1 && n < 2000) begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    check("trip delay", n, code * step + 3);
    over_limit_pin[ch] = 1'b0;
    n = 0;
    while (channel_trip[ch] !== 1'b0 && n < 10) begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    check("trip release", n, 3);
  endtask

  // ==========================================================
  // main sequence
  initial begin
    int n;
    logic [7:0] d;
    repeat (12) @(posedge ref_clk);
    #1;
    rst = 1'b0;
    @(posedge ref_clk);
    #1;
    check("reset gain", sense2_cfg.amp_gain, 8'h14);
    check("reset thr dv", sense2_cfg.threshold_dv, 8'h1e);
    // reset values, back to back, plus an unmapped address
    rd(8'h1a, 8'h04, 1);
    rd(8'h1b, 8'h1d, 1);
    rd(8'h1c, 8'h05, 1);
    rd(8'h1d, 8'h00, 1);
    rd(8'h1e, 8'h05, 1);
    rd(8'h1f, 8'h00, 1);
    rd(8'h20, 8'h00, 0);
    // random write burst, unmapped write ignored, then read-back burst
    for (int i = 0; i < 6; i++) begin
      d = 8'($random(seed));
      shadow[i] = d & mask[i];
      wr(8'h1a + 8'(i), d);
    end
    wr(8'h20, 8'hff);
    for (int i = 0; i < 6; i++) begin
      rd(8'h1a + 8'(i), shadow[i], 1);
    end
    rd(8'h20, 8'h00, 0);
    idle();
    check("sense3 copy", sense3_ctrl, shadow[3]);
    // every threshold code, gain select following the code's low bit
    for (int c = 0; c < 32; c++) begin
      d = {1'b0, 1'(c), 1'b0, 5'(c)};
      wr(8'h1b, d);
      idle();
      @(posedge ref_clk);
      #1;
      check("gain", sense2_cfg.amp_gain, (c % 2) ? 8'h28 : 8'h14);
      check("thr code", sense2_cfg.limit_threshold_two, c);
      check("thr dv", sense2_cfg.threshold_dv, (c <= 4) ? 5 : c + 1);
    end
    // persistence delays at boundary codes on every channel
    trip(0, 6'h00, S1);
    trip(0, 6'h01, S1);
    trip(0, 6'h3f, S1);
    trip(1, 6'h00, S2);
    trip(1, 6'h3f, S2);
    trip(2, 6'h3f, S2);
    trip(2, 6'h07, S2);
    // a one-cycle dip restarts the count
    wr(8'h1c, 8'h0a);
    idle();
    over_limit_pin[1] = 1'b1;
    repeat (9) @(posedge ref_clk);
    #1;
    over_limit_pin[1] = 1'b0;
    @(posedge ref_clk);
    #1;
    over_limit_pin[1] = 1'b1;
    n = 0;
    while (channel_trip[1] !== 1'b1 && n < 200) begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    check("restart delay", n, 13);
    over_limit_pin[1] = 1'b0;
    repeat (5) @(posedge ref_clk);
    check("answers left", exp_q.size(), 0);
    results();
  end
endmodule
